// file: core/ccd_clock_divider.sv
`timescale 1ns/100ps
// ==========================================================
// codec clock generator: filter clock and transmit/receive bit clocks
module ccd_clock_divider
  import ccd_pkg::*;
(
  // clock and reset (clock is the master clock)
  input wire logic clock,
  input wire logic rst,
  // register port
  input wire logic [7:0] reg_addr,
  input wire logic reg_wr,
  input wire logic [15:0] reg_wdata,
  input wire logic reg_rd,
  output logic [15:0] reg_rdata,
  // coding mode from the codec
  input wire logic pcm_mode,
  input wire logic unbuffered_req,
  // bit clock source selection and external bit clock pins
  input wire logic tx_clk_external,
  input wire logic rx_clk_external,
  input wire logic tx_clk_pin,
  input wire logic rx_clk_pin,
  // generated enables
  output logic audio_filter_clock_en,
  output logic tx_bit_en,
  output logic rx_bit_en,
  output logic burst_select
);

  logic [15:0] ctrl_ff;
  logic [15:0] reg_rdata_ff;
  logic ctrl_wr;
  logic [1:0] filt_pre_cnt_ff;
  logic [1:0] bit_pre_cnt_ff;
  logic filt_pre_en;
  logic bit_pre_en;
  logic [2:0] filt_code;
  logic [1:0] filt_pre;
  logic [1:0] bit_pre;
  logic burst_ff;
  logic tx_bit_en_ff;
  logic rx_bit_en_ff;
  logic [1:0] int_en;
  logic [1:0] ext_edge;
  logic [1:0] use_ext;
  logic [1:0] pin_in;
  logic [2:0] ch_code [2];

  assign ctrl_wr = reg_wr && reg_addr == CCD_CTRL_ADDR;
  assign filt_code = ctrl_ff[CCD_FILT_DIV_LSB +: 3];
  assign filt_pre = ctrl_ff[CCD_FILT_PRE_LSB +: 2];
  assign bit_pre = ctrl_ff[CCD_BIT_PRE_LSB +: 2];
  assign ch_code[0] = ctrl_ff[CCD_TX_DIV_LSB +: 3];
  assign ch_code[1] = ctrl_ff[CCD_RX_DIV_LSB +: 3];
  assign use_ext = {rx_clk_external, tx_clk_external};
  assign pin_in = {rx_clk_pin, tx_clk_pin};

  // ==========================================================
  // divider control register; reserved bits store and read as zero
  always_ff @(posedge clock) begin
    if (rst) begin
      ctrl_ff <= CCD_CTRL_RESET;
    end else if (ctrl_wr) begin
      ctrl_ff <= reg_wdata & CCD_CTRL_MASK;
    end
  end

  // read data is registered; unmapped addresses answer zero
  always_ff @(posedge clock) begin
    if (rst) begin
      reg_rdata_ff <= CCD_RD_UNMAPPED;
    end else if (reg_rd) begin
      reg_rdata_ff <= (reg_addr == CCD_CTRL_ADDR) ? ctrl_ff : CCD_RD_UNMAPPED;
    end
  end
  assign reg_rdata = reg_rdata_ff;

  // ==========================================================
  // filter path prescaler, codes 00..11 divide by 1..4
  always_ff @(posedge clock) begin
    if (rst || ctrl_wr) begin
      filt_pre_cnt_ff <= 2'h0;
    end else if (filt_pre_cnt_ff >= filt_pre) begin
      filt_pre_cnt_ff <= 2'h0;
    end else begin
      filt_pre_cnt_ff <= filt_pre_cnt_ff + 2'h1;
    end
  end
  assign filt_pre_en = !ctrl_wr && filt_pre_cnt_ff >= filt_pre;

  // fractional filter divider; a write restarts it so no runt period leaks out
  ccd_frac_div u_filt_div (
    .clock(clock),
    .rst(rst),
    .restart(ctrl_wr),
    .in_en(filt_pre_en),
    .num(ccd_filt_num(filt_code)),
    .step(CCD_FILT_STEP),
    .out_en_ff(audio_filter_clock_en)
  );

  // ==========================================================
  // bit path prescaler shared by both bit clocks
  // a small prescaler output rate saves power, so software should favour it
  always_ff @(posedge clock) begin
    if (rst || ctrl_wr) begin
      bit_pre_cnt_ff <= 2'h0;
    end else if (bit_pre_cnt_ff >= bit_pre) begin
      bit_pre_cnt_ff <= 2'h0;
    end else begin
      bit_pre_cnt_ff <= bit_pre_cnt_ff + 2'h1;
    end
  end
  assign bit_pre_en = !ctrl_wr && bit_pre_cnt_ff >= bit_pre;

  // ==========================================================
  // per channel: fractional divider, fixed /64, and external pin sync
  // channel 0 transmit, channel 1 receive; the two run independently
  generate
    for (genvar ch = 0; ch < 2; ch++) begin : g_chan
      logic frac_en;
      logic [5:0] fix_cnt_ff;
      logic int_en_ff;
      logic [2:0] sync_ff;
      logic level_ff;

      ccd_frac_div u_bit_div (
        .clock(clock),
        .rst(rst),
        .restart(ctrl_wr),
        .in_en(bit_pre_en),
        .num(ccd_bit_num(ch_code[ch])),
        .step(CCD_BIT_STEP),
        .out_en_ff(frac_en)
      );

      // fixed divide by 64 after the fractional stage
      always_ff @(posedge clock) begin
        if (rst || ctrl_wr) begin
          fix_cnt_ff <= 6'h00;
          int_en_ff <= 1'b0;
        end else if (frac_en) begin
          fix_cnt_ff <= fix_cnt_ff + 6'h01;
          int_en_ff <= fix_cnt_ff == CCD_BIT_FIXED_LAST;
        end else begin
          int_en_ff <= 1'b0;
        end
      end
      assign int_en[ch] = int_en_ff;

      // three-stage sync; stage one feeds stage two only
      always_ff @(posedge clock) begin
        if (rst) begin
          sync_ff <= 3'h0;
          level_ff <= 1'b0;
        end else begin
          sync_ff <= {sync_ff[1:0], pin_in[ch]};
          if (sync_ff[2] == sync_ff[1]) begin
            level_ff <= sync_ff[2];
          end
        end
      end
      // rising edge once stages two and three agree
      assign ext_edge[ch] = sync_ff[2] == sync_ff[1] && sync_ff[2] && !level_ff;
    end
  endgenerate

  // ==========================================================
  // pcm always uses the burst interface; only delta modulation goes unbuffered
  always_ff @(posedge clock) begin
    if (rst) begin
      burst_ff <= 1'b1;
    end else begin
      burst_ff <= pcm_mode || !unbuffered_req;
    end
  end
  assign burst_select = burst_ff;

  // bit clock source select; receive source chosen apart from transmit
  // in burst mode the serial bit clocks are held off
  always_ff @(posedge clock) begin
    if (rst) begin
      tx_bit_en_ff <= 1'b0;
      rx_bit_en_ff <= 1'b0;
    end else begin
      tx_bit_en_ff <= !burst_ff && (use_ext[0] ? ext_edge[0] : int_en[0]);
      rx_bit_en_ff <= !burst_ff && (use_ext[1] ? ext_edge[1] : int_en[1]);
    end
  end
  assign tx_bit_en = tx_bit_en_ff;
  assign rx_bit_en = rx_bit_en_ff;

  // ==========================================================
  // checks
  default clocking cb @(posedge clock); endclocking
  default disable iff (rst);

  AST_CTRL_WRITE: assert property (ctrl_wr |=> ctrl_ff == ($past(reg_wdata) & CCD_CTRL_MASK))
    else $error("control register did not take the write");
  AST_FILT_STOP: assert property ((filt_code == 3'h0 && $past(filt_code) == 3'h0
      && !$past(ctrl_wr)) |-> !audio_filter_clock_en)
    else $error("filter clock runs with divider code zero");
  // a write may switch to a shorter prescale, so only a steady divide-by-four is held to it
  AST_FILT_PRE4: assert property ((filt_pre == 2'h3 && filt_pre_en) |=>
      (!filt_pre_en || filt_pre != 2'h3) [*3])
    else $error("filter prescaler by four pulsed too often");
  AST_BIT_PRE1: assert property ((bit_pre == 2'h0 && !ctrl_wr && $past(bit_pre) == 2'h0)
      |-> bit_pre_en)
    else $error("bit prescaler by one missed a cycle");
  AST_TX_FIXED64: assert property (int_en[0] |-> $past(g_chan[0].fix_cnt_ff) == 6'h3f)
    else $error("transmit bit pulse not on the 64th divider output");
  AST_TX_INTERNAL: assert property ((!burst_ff && !tx_clk_external && int_en[0])
      |=> tx_bit_en)
    else $error("internal transmit bit clock not passed through");
  AST_RX_EXTERNAL: assert property ((!burst_ff && rx_clk_external && ext_edge[1])
      |=> rx_bit_en)
    else $error("external receive bit clock edge not passed through");
  AST_PCM_BURST: assert property (pcm_mode |=> burst_select ##1 (!tx_bit_en && !rx_bit_en))
    else $error("pcm mode allowed unbuffered bit clocks");
  AST_RX_SPACING: assert property ((!rx_clk_external && rx_bit_en) |=> !rx_bit_en)
    else $error("internal receive bit pulses back to back");

  COV_FILT_RUN: cover property (audio_filter_clock_en ##1 !audio_filter_clock_en);
  COV_TX_INT: cover property (!tx_clk_external && tx_bit_en);
  COV_RX_EXT: cover property (rx_clk_external && rx_bit_en);
  COV_PCM: cover property (pcm_mode && unbuffered_req ##1 burst_select);

endmodule : ccd_clock_divider

// file: core/ccd_frac_div.sv
`timescale 1ns/100ps
// ==========================================================
// fractional divider: out rate = in rate * step / num
module ccd_frac_div
  import ccd_pkg::*;
(
  // clock and reset
  input wire logic clock,
  input wire logic rst,
  // control
  input wire logic restart,
  input wire logic in_en,
  input wire logic [7:0] num,
  input wire logic [3:0] step,
  // result
  output logic out_en_ff
);

  logic [7:0] acc_ff;
  logic [8:0] sum;

  assign sum = {1'b0, acc_ff} + {5'h00, step};

  // accumulate; a zero divisor parks the divider with no output
  always_ff @(posedge clock) begin
    if (rst || restart) begin
      acc_ff <= 8'h00;
      out_en_ff <= 1'b0;
    end else if (in_en && num != 8'h00) begin
      if (sum >= {1'b0, num}) begin
        acc_ff <= 8'(sum - {1'b0, num});
        out_en_ff <= 1'b1;
      end else begin
        acc_ff <= sum[7:0];
        out_en_ff <= 1'b0;
      end
    end else begin
      out_en_ff <= 1'b0;
    end
  end

  default clocking cb @(posedge clock); endclocking
  default disable iff (rst);

  AST_FRAC_SUBSET: assert property (out_en_ff |-> $past(in_en))
    else $error("divider output without input pulse");
  AST_FRAC_ZERO: assert property ((num == 8'h00 && !restart) |=> !out_en_ff)
    else $error("parked divider produced a pulse");

endmodule : ccd_frac_div

// file: core/ccd_pkg.sv
// How it works
// - each bit clock internal or external
// - only delta modulation runs unbuffered serial
// - filter clock = master / prescaler / divider
// - bit prescaler and two fractional divider fields
package ccd_pkg;

  // ==========================================================
  // register map
  localparam logic [7:0] CCD_CTRL_ADDR = 8'h72;
  localparam logic [15:0] CCD_CTRL_RESET = 16'h0000;
  localparam logic [15:0] CCD_CTRL_MASK = 16'h1fff;
  localparam logic [15:0] CCD_RD_UNMAPPED = 16'h0000;

  // ==========================================================
  // field positions (low bit of each field)
  localparam int CCD_FILT_PRE_LSB = 11;
  localparam int CCD_FILT_DIV_LSB = 8;
  localparam int CCD_BIT_PRE_LSB = 6;
  localparam int CCD_TX_DIV_LSB = 3;
  localparam int CCD_RX_DIV_LSB = 0;

  // ==========================================================
  // divider arithmetic: divisors held in fractions of one
  localparam logic [3:0] CCD_FILT_STEP = 4'h4;   // quarters
  localparam logic [3:0] CCD_BIT_STEP = 4'h8;    // eighths
  localparam logic [5:0] CCD_BIT_FIXED_LAST = 6'h3f;  // fixed divide by 64

  typedef logic [7:0] ccd_num_type;

  // filter divisor in quarters; code 000 stops the filter clock
  function automatic ccd_num_type ccd_filt_num(input logic [2:0] code);
    unique case (code)
      3'h0: ccd_filt_num = 8'h00;
      3'h1: ccd_filt_num = 8'h20;  // 8
      3'h2: ccd_filt_num = 8'h3e;  // 15.5
      3'h3: ccd_filt_num = 8'h3f;  // 15.75
      3'h4: ccd_filt_num = 8'h40;  // 16
      3'h5: ccd_filt_num = 8'h58;  // 22
      3'h6: ccd_filt_num = 8'h7d;  // 31.25
      3'h7: ccd_filt_num = 8'hbf;  // 47.75
    endcase
  endfunction : ccd_filt_num

  // bit divisor in eighths
  function automatic ccd_num_type ccd_bit_num(input logic [2:0] code);
    unique case (code)
      3'h0: ccd_bit_num = 8'h08;  // 1
      3'h1: ccd_bit_num = 8'h10;  // 2
      3'h2: ccd_bit_num = 8'h12;  // 2.25
      3'h3: ccd_bit_num = 8'h15;  // 2.625
      3'h4: ccd_bit_num = 8'h18;  // 3
      3'h5: ccd_bit_num = 8'h19;  // 3.125
      3'h6: ccd_bit_num = 8'h1b;  // 3.375
      3'h7: ccd_bit_num = 8'h1c;  // 3.5
    endcase
  endfunction : ccd_bit_num

endpackage : ccd_pkg

// file: verification/ccd_clock_divider_test.sv
`timescale 1ns/100ps
`define CHECK(nm, ex, got) begin checked++; if ((got) !== (ex)) begin num_errors++; \
  $display("[FAIL] %s expected %0h seen %0h", nm, ex, got); end end
// ==========================================================
// bench: divider table, then mask, reset, burst and external cases
module ccd_clock_divider_test;
  import ccd_pkg::*;
  logic clock, rst, reg_wr, reg_rd, pcm_mode, unbuffered_req, tx_ext, rx_ext, run;
  logic [7:0] reg_addr;
  logic [15:0] reg_wdata, reg_rdata, rd;
  logic filt_en, tx_bit_en, rx_bit_en, burst_select, tx_pin, rx_pin;
  int num_errors = 0;
  int checked = 0;
  int cyc, i;
  // spans in master cycles: 4 filter pulses, 1 tx bit, 1 rx bit
  // rows 2 and 3 pair high prescalers with low dividers, the host's power-saving choice
  logic [15:0] row_ctrl [8] = '{16'h0107, 16'h0a4e, 16'h1395, 16'h1cdc,
    16'h0523, 16'h062a, 16'h0731, 16'h0038};
  int row_filt [8] = '{32, 124, 189, 256, 88, 125, 191, 0};
  int row_tx [8] = '{64, 256, 432, 672, 192, 200, 216, 224};
  int row_rx [8] = '{224, 432, 600, 768, 168, 144, 128, 64};

  ccd_clock_divider u_ccd_clock_divider (.clock(clock), .rst(rst), .reg_addr(reg_addr),
    .reg_wr(reg_wr), .reg_wdata(reg_wdata), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
    .pcm_mode(pcm_mode), .unbuffered_req(unbuffered_req), .tx_clk_external(tx_ext),
    .rx_clk_external(rx_ext), .tx_clk_pin(tx_pin), .rx_clk_pin(rx_pin),
    .audio_filter_clock_en(filt_en), .tx_bit_en(tx_bit_en), .rx_bit_en(rx_bit_en),
    .burst_select(burst_select));
  ccd_ext_clock_source u_ccd_ext_clock_source (.run(run), .tx_clk_pin(tx_pin),
    .rx_clk_pin(rx_pin));

  // ==========================================================
  // clock, inputs at time zero
  initial begin
    clock = 1'b0;
    // 10 MHz master sits above the crystal floor, so no external master is needed
    forever #50 clock = ~clock;
  end
  // reset stands from time zero so the first edge already clears the design
  initial begin
    rst = 1'b1;
    {reg_wr, reg_rd, pcm_mode, tx_ext, rx_ext, run} = '0;
    unbuffered_req = 1'b1;
    reg_addr = 8'h00;
    reg_wdata = 16'h0000;
  end

  // ==========================================================
  // register access, one strobe cycle each
  task automatic wr(input logic [7:0] a, input logic [15:0] d);
    @(posedge clock);
    reg_wr <= 1'b1;
    reg_addr <= a;
    reg_wdata <= d;
    @(posedge clock);
    reg_wr <= 1'b0;
  endtask : wr
  task automatic rdr(input logic [7:0] a);
    @(posedge clock);
    reg_rd <= 1'b1;
    reg_addr <= a;
    @(posedge clock);
    reg_rd <= 1'b0;
    @(negedge clock);
    rd = reg_rdata;
  endtask : rdr
  // cycles from one pulse to the n-th after it; 0 if none come
  task automatic span(input int k, input int n, output int c);
    int seen;
    int t;
    seen = -1;
    c = 0;
    for (t = 0; t < 4000 && seen < n; t++) begin
      @(negedge clock);
      if (seen >= 0) c++;
      if (((k == 0) ? filt_en : (k == 1) ? tx_bit_en : rx_bit_en) === 1'b1) seen++;
    end
    if (seen < n) c = 0;
  endtask : span

  task automatic finish_test;
    $display("checked %0d num_errors %0d", checked, num_errors);
    if (num_errors == 0 && checked > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask : finish_test

  // the full run needs about 2 ms; a hang is caught at 6 ms, 60k cycles
  initial begin
    #6ms;
    num_errors++;
    finish_test();
  end

  // ==========================================================
  // main sequence
  initial begin
    repeat (4) @(posedge clock);
    rst <= 1'b0;
    @(negedge clock);
    `CHECK("burst_select", 1'b1, burst_select)
    // table: every prescaler and divider code on every path
    for (i = 0; i < 8; i++) begin
      wr(CCD_CTRL_ADDR, row_ctrl[i]);
      rdr(CCD_CTRL_ADDR);
      `CHECK("ctrl", row_ctrl[i], rd)
      span(0, 4, cyc);
      `CHECK("filter span", row_filt[i], cyc)
      span(1, 1, cyc);
      `CHECK("tx span", row_tx[i], cyc)
      span(2, 1, cyc);
      `CHECK("rx span", row_rx[i], cyc)
    end
    // top bits dropped, unmapped address reads zero and ignores writes
    wr(CCD_CTRL_ADDR, 16'hffff);
    wr(8'h73, 16'h0000);
    rdr(CCD_CTRL_ADDR);
    `CHECK("ctrl mask", 16'h1fff, rd)
    rdr(8'h73);
    `CHECK("unmapped", CCD_RD_UNMAPPED, rd)
    // reset in mid-run clears the register
    @(posedge clock);
    rst <= 1'b1;
    @(posedge clock);
    rst <= 1'b0;
    rdr(CCD_CTRL_ADDR);
    `CHECK("ctrl reset", CCD_CTRL_RESET, rd)
    // pcm or no unbuffered request: burst interface, bit enables quiet
    @(posedge clock);
    pcm_mode <= 1'b1;
    span(1, 1, cyc);
    `CHECK("pcm tx quiet", 0, cyc)
    `CHECK("burst pcm", 1'b1, burst_select)
    @(posedge clock);
    pcm_mode <= 1'b0;
    unbuffered_req <= 1'b0;
    span(2, 1, cyc);
    `CHECK("burst rx quiet", 0, cyc)
    @(posedge clock);
    unbuffered_req <= 1'b1;
    span(1, 1, cyc);
    `CHECK("unbuffered tx", 64, cyc)
    `CHECK("burst off", 1'b0, burst_select)
    // external bit clocks: tx 20 cycles, rx 30 cycles
    @(posedge clock);
    run <= 1'b1;
    tx_ext <= 1'b1;
    rx_ext <= 1'b1;
    repeat (40) @(posedge clock);
    span(1, 1, cyc);
    `CHECK("ext tx", 20, cyc)
    span(2, 1, cyc);
    `CHECK("ext rx", 30, cyc)
    @(posedge clock);
    rx_ext <= 1'b0;
    repeat (10) @(posedge clock);
    span(2, 1, cyc);
    `CHECK("int rx", 64, cyc)
    finish_test();
  end
endmodule : ccd_clock_divider_test

// file: verification/ccd_ext_clock_source.sv
`timescale 1ns/100ps
// ==========================================================
// external bit clock source: free of the master clock's phase
module ccd_ext_clock_source #(
  parameter int TX_HALF_NS = 1000,
  parameter int RX_HALF_NS = 1500
) (
  // control
  input wire logic run,
  // external bit clocks
  output logic tx_clk_pin,
  output logic rx_clk_pin
);
  // tx and rx differ in rate and phase; both stand low outside a run
  initial begin
    tx_clk_pin = 1'b0;
    #37;
    forever begin
      #(TX_HALF_NS) tx_clk_pin = run ? ~tx_clk_pin : 1'b0;
    end
  end
  initial begin
    rx_clk_pin = 1'b0;
    #61;
    forever begin
      #(RX_HALF_NS) rx_clk_pin = run ? ~rx_clk_pin : 1'b0;
    end
  end
endmodule : ccd_ext_clock_source
